// ---- hw/fpc_pkg.sv ----
package fpc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_DUTY     = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;

  // Prescale register fields
  localparam int unsigned PS_SEL_BIT  = 7;
  localparam int unsigned PS_DIV_MSB  = 6;
  localparam int unsigned PS_DIV_W    = 7;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_INV_BIT = 1;

  // Status register fields
  localparam int unsigned ST_CNT_LSB  = 0;
  localparam int unsigned ST_PWM_BIT  = 8;
  localparam int unsigned ST_OUT_BIT  = 9;

  // Values after reset
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_DUTY     = 8'hFF;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [6:0] RST_DIV_CNT  = 7'h00;

  // Duty value that holds the output high for the whole period
  localparam logic [7:0] DUTY_FULL    = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    FPC_REG_PRESCALE,
    FPC_REG_DUTY,
    FPC_REG_CTRL,
    FPC_REG_STATUS,
    FPC_REG_NONE
  } fpc_reg_e;

endpackage : fpc_pkg

// ---- hw/fpc_div.sv ----
// Turns source ticks into one counter step per (divide field + 1) ticks.
module fpc_div
(
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         run,
  input  wire logic                         src_tick,
  input  wire logic [fpc_pkg::PS_DIV_W-1:0] div_field,
  output logic                              step
);

  typedef struct packed {
    logic [fpc_pkg::PS_DIV_W-1:0] cnt;
    logic                         step;
  } fpc_div_s;

  fpc_div_s st_q;
  fpc_div_s st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.step = 1'b0;
    if (!run)
    begin
      st_d.cnt = fpc_pkg::RST_DIV_CNT;
    end
    else if (src_tick)
    begin
      // A zero field steps on every tick: straight pass-through
      if (st_q.cnt == div_field)
      begin
        st_d.cnt  = fpc_pkg::RST_DIV_CNT;
        st_d.step = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q.cnt  <= fpc_pkg::RST_DIV_CNT;
      st_q.step <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign step = st_q.step;

endmodule : fpc_div

// ---- hw/fpc_top.sv ----
// Functional notes
// - Eight-bit counter wraps continuously; one period is 256 divided-clock steps.
// - Modulated signal is high while the count is below the duty value.
// - Duty 00h is always low, FFh always high, else duty high cycles.
// - Invert control presents the inverse of the modulated signal on the pin.
// - Prescale bit 7 selects the fast source at 0, slow source at 1.
// - Selected source divided by prescale field plus one; zero passes straight through.
// - Reset gives fast source, zero prescale field and duty of all ones.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module fpc_top
(
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        src_fast_tick,
  input  wire logic                        src_slow_tick,
  output logic                             fan_drive_out,
  input  wire logic [fpc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [fpc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [fpc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [fpc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        aw_have;
    logic [fpc_pkg::ADDR_W-1:0]  aw_addr;
    logic                        w_have;
    logic [7:0]                  w_byte;
    logic                        w_lane0;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [fpc_pkg::DATA_W-1:0]  rdata;
    logic [1:0]                  rresp;
    logic [7:0]                  prescale;
    logic [7:0]                  duty;
    logic [7:0]                  duty_act;
    logic                        enable;
    logic                        invert;
    logic [7:0]                  count;
    logic                        pwm;
    logic                        fan_out;
  } fpc_state_s;

  fpc_state_s st_q;
  fpc_state_s st_d;

  logic src_tick;
  logic step;

  // Used by both the write and the read path
  function automatic fpc_pkg::fpc_reg_e reg_decode(input logic [fpc_pkg::ADDR_W-1:0] addr);
    unique case (addr)
      fpc_pkg::OFS_PRESCALE: reg_decode = fpc_pkg::FPC_REG_PRESCALE;
      fpc_pkg::OFS_DUTY:     reg_decode = fpc_pkg::FPC_REG_DUTY;
      fpc_pkg::OFS_CTRL:     reg_decode = fpc_pkg::FPC_REG_CTRL;
      fpc_pkg::OFS_STATUS:   reg_decode = fpc_pkg::FPC_REG_STATUS;
      default:               reg_decode = fpc_pkg::FPC_REG_NONE;
    endcase
  endfunction : reg_decode

  // Source selection is a plain mux; glitch-free switching is not needed
  // since software only changes it while the function is off
  assign src_tick = st_q.prescale[fpc_pkg::PS_SEL_BIT] ? src_slow_tick : src_fast_tick;

  fpc_div u_div
  (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .run       (st_q.enable),
    .src_tick  (src_tick),
    .div_field (st_q.prescale[fpc_pkg::PS_DIV_MSB:0]),
    .step      (step)
  );

  always_comb
  begin
    fpc_pkg::fpc_reg_e wsel;
    fpc_pkg::fpc_reg_e rsel;
    wsel = reg_decode(st_q.aw_addr);
    rsel = reg_decode(s_axi_araddr);
    st_d = st_q;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_have  = 1'b1;
      st_d.w_byte  = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end

    // Commit once both halves are held and no response is pending
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wsel == fpc_pkg::FPC_REG_NONE) ? fpc_pkg::RESP_SLVERR
                                                     : fpc_pkg::RESP_OKAY;
      if (st_q.w_lane0)
      begin
        unique case (wsel)
          fpc_pkg::FPC_REG_PRESCALE: st_d.prescale = st_q.w_byte;
          fpc_pkg::FPC_REG_DUTY:     st_d.duty     = st_q.w_byte;
          fpc_pkg::FPC_REG_CTRL:
          begin
            st_d.enable = st_q.w_byte[fpc_pkg::CTRL_EN_BIT];
            st_d.invert = st_q.w_byte[fpc_pkg::CTRL_INV_BIT];
          end
          fpc_pkg::FPC_REG_STATUS:   st_d.prescale = st_q.prescale;
          fpc_pkg::FPC_REG_NONE:     st_d.prescale = st_q.prescale;
        endcase
      end
    end
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready  = !st_d.w_have && !st_d.bvalid;

    // Read path: one read at a time, answered the cycle after the address
    if (s_axi_rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = '0;
      st_d.rresp  = fpc_pkg::RESP_OKAY;
      unique case (rsel)
        fpc_pkg::FPC_REG_PRESCALE: st_d.rdata[7:0] = st_q.prescale;
        fpc_pkg::FPC_REG_DUTY:     st_d.rdata[7:0] = st_q.duty;
        fpc_pkg::FPC_REG_CTRL:
        begin
          st_d.rdata[fpc_pkg::CTRL_EN_BIT]  = st_q.enable;
          st_d.rdata[fpc_pkg::CTRL_INV_BIT] = st_q.invert;
        end
        fpc_pkg::FPC_REG_STATUS:
        begin
          st_d.rdata[fpc_pkg::ST_CNT_LSB +: 8] = st_q.count;
          st_d.rdata[fpc_pkg::ST_PWM_BIT]      = st_q.pwm;
          st_d.rdata[fpc_pkg::ST_OUT_BIT]      = st_q.fan_out;
        end
        fpc_pkg::FPC_REG_NONE:     st_d.rresp = fpc_pkg::RESP_SLVERR;
      endcase
    end
    st_d.arready = !st_d.rvalid;

    // Counter and compare
    if (!st_q.enable)
    begin
      st_d.count    = fpc_pkg::RST_COUNT;
      st_d.duty_act = st_d.duty;
    end
    else if (step)
    begin
      st_d.count = st_q.count + 8'h01;
      // While running, duty is sampled only at the wrap, so a pulse is never cut or stretched; while disabled it follows the duty register
      if (st_d.count == fpc_pkg::RST_COUNT)
      begin
        st_d.duty_act = st_q.duty;
      end
    end

    if (!st_d.enable)
    begin
      st_d.pwm = 1'b0;
    end
    else
    begin
      st_d.pwm = (st_d.duty_act == fpc_pkg::DUTY_FULL) ||
                 (st_d.count < st_d.duty_act);
    end
    st_d.fan_out = st_d.pwm ^ st_d.invert;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q          <= '0;
      st_q.awready  <= 1'b1;
      st_q.wready   <= 1'b1;
      st_q.arready  <= 1'b1;
      st_q.prescale <= fpc_pkg::RST_PRESCALE;
      st_q.duty     <= fpc_pkg::RST_DUTY;
      st_q.duty_act <= fpc_pkg::RST_DUTY;
      st_q.count    <= fpc_pkg::RST_COUNT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign fan_drive_out = st_q.fan_out;
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

endmodule : fpc_top

// ---- tb/fpc_checker.sv ----
module fpc_checker
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        src_fast_tick,
  input wire logic        src_slow_tick,
  input wire logic        fan_drive_out,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Checked through the reset itself, so it overrides the default disable
  property p_rst_idle;
    disable iff (1'b0) sys_rst |=> !fan_drive_out && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("state after reset wrong");
  // The pin only moves after a source tick or a committed register write
  property p_pin_cause;
    $changed(fan_drive_out) |->
      $past(src_fast_tick, 2) || $past(src_slow_tick, 2) || $rose(s_axi_bvalid);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved without cause");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_rd_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
      |=> s_axi_rresp == fpc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered");
endmodule : fpc_checker

// ---- tb/fpc_fan_model.sv ----
// Fan seen as an averaging load: it only integrates the time the drive is high
module fpc_fan_model
(
  input wire logic        ref_clk,
  input wire logic        clr,
  input wire logic        fan_drive_out,
  output logic [15:0]     high_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge ref_clk)
    high_cnt <= clr ? 16'h0 : high_cnt + {15'h0, fan_drive_out};
endmodule : fpc_fan_model

// ---- tb/fpc_top_bench.sv ----
module fpc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, sys_rst = 1, src_fast_tick = 0, src_slow_tick = 0;
  logic        slow_on = 0, clr = 0, fan_drive_out;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, rnd = 32'h8A71E633;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] high_cnt;
  logic [7:0]  duty_tab [5] = '{8'h00, 8'h01, 8'h80, 8'hFE, 8'hFF};
  int          fail_count = 0, n_compared = 0;

  always #50 ref_clk = ~ref_clk;
  // Fast source ticks every other cycle so a wrong source select changes the period
  always @(posedge ref_clk)
  begin
    src_fast_tick <= ~src_fast_tick;
    src_slow_tick <= slow_on;
  end

  fpc_top uut (.*);
  fpc_fan_model fan (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic limit(input int n);
    if (n >= 100)
    begin
      fail_count++;
      print_verdict();
    end
  endtask : limit

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    limit(n);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    // Let an edge pass so a following write never re-raises bready in this time step
    @(posedge ref_clk);
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    limit(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Let an edge pass so a following read never re-raises rready in this time step
    @(posedge ref_clk);
  endtask : rdr

  // Counts drive-high cycles over a window of n cycles
  task automatic span(input int n, input int exp);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge ref_clk);
    chk({16'h0, high_cnt}, 32'(exp));
  endtask : span

  // One full period: (field + 1) * 256 ticks, fast ticks arrive every second cycle
  task automatic run(input logic [7:0] ps, input logic [7:0] d, input logic inv);
    int p, h;
    p = 256 * (ps[6:0] + 1) * (ps[7] ? 1 : 2);
    h = (d == 8'hFF) ? p : d * p / 256;
    slow_on <= ps[7];
    wr(8'h00, {24'h0, ps}, 2'h0);
    wr(8'h04, {24'h0, d}, 2'h0);
    wr(8'h08, {30'h0, inv, 1'b1}, 2'h0);
    repeat (20) @(posedge ref_clk);
    span(p, inv ? p - h : h);
    wr(8'h08, 32'h0, 2'h0);
    rdr(8'h00, rd, rs);
    chk(rd, {24'h0, ps});
  endtask : run

  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdr(8'h00, rd, rs);
    chk(rd, 32'h0);
    rdr(8'h04, rd, rs);
    chk(rd, 32'hFF);
    rdr(8'h10, rd, rs);
    chk({30'h0, rs}, {30'h0, fpc_pkg::RESP_SLVERR});
    wr(8'h10, 32'h5A, fpc_pkg::RESP_SLVERR);
    for (int i = 0; i < 10; i++)
      run(8'h00, duty_tab[i / 2], i[0]);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      run({rnd[7], 5'h0, rnd[9:8]}, rnd[23:16], rnd[24]);
    end
    slow_on <= 1'b0;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h04, 32'h40, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    repeat (200) @(posedge ref_clk);
    // Count is past the old pulse, so the new duty must wait for the wrap
    wr(8'h04, 32'hC0, 2'h0);
    span(150, 0);
    wr(8'h08, 32'h0, 2'h0);
    repeat (10) @(posedge ref_clk);
    rdr(8'h0C, rd, rs);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule : fpc_top_bench

bind fpc_top fpc_checker chk_i (.*);
